// *** common/pro_pkg.sv ***
/*
  Package for the programmable relay output block: selector codes, fault codes,
  delay limits and timebase constants.
  Assumes a single 100 MHz core clock.
*/
package pro_pkg;

  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned TICK_S          = 1;
  localparam int unsigned TICK_CYCLES     = CLK_HZ * TICK_S;
  localparam int unsigned READY_HOLD_S    = 1;

  localparam logic [9:0]  DELAY_MAX       = 10'h3e7;
  localparam logic [9:0]  DELAY_RESET     = 10'h000;
  localparam logic [4:0]  SEL_RESET       = 5'h06;
  localparam logic [4:0]  SEL_MAX         = 5'h13;
  localparam logic [4:0]  SEL_INVERT_BASE = 5'h0a;

  localparam logic [2:0]  TRIG_START_CMD  = 3'h0;
  localparam logic [2:0]  TRIG_STARTING   = 3'h1;
  localparam logic [2:0]  TRIG_BYPASS     = 3'h2;
  localparam logic [2:0]  TRIG_STOP_CMD   = 3'h3;
  localparam logic [2:0]  TRIG_SHUTDOWN   = 3'h4;
  localparam logic [2:0]  ST_FAULT        = 3'h5;
  localparam logic [2:0]  ST_OPERATING    = 3'h6;
  localparam logic [2:0]  ST_READY        = 3'h7;
  localparam logic [3:0]  SEL_ST_STARTING = 4'h8;
  localparam logic [3:0]  SEL_ST_BYPASS   = 4'h9;

  localparam logic [4:0]  FLT_OUT_PHASE   = 5'h05;
  localparam logic [4:0]  FLT_06          = 5'h06;
  localparam logic [4:0]  FLT_07          = 5'h07;
  localparam logic [4:0]  FLT_08          = 5'h08;
  localparam logic [4:0]  FLT_12          = 5'h0c;
  localparam logic [4:0]  FLT_15          = 5'h0f;

endpackage

// *** core/pro_tick.sv ***
/*
  Seconds timebase: one-cycle pulse every TICKS cycles, restartable.
  Assumes the core clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module pro_tick #(
  parameter int unsigned TICKS = pro_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  // Control
  input  wire logic restart_i,
  output logic      tick_o
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } pro_tick_st_t;

  pro_tick_st_t s_q;
  pro_tick_st_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    // Restart aligns the first second to the trigger rather than a free phase.
    if (restart_i || s_q.cnt == 32'(TICKS - 1)) begin
      s_d.cnt  = 32'h0;
      s_d.tick = !restart_i;
    end else begin
      s_d.cnt = s_q.cnt + 32'h1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick_o = s_q.tick;
endmodule // pro_tick

// *** core/pro_relay.sv ***
/*
  Programmable relay output: timed mode (selector 0-4/10-14) and state mode
  (5-9/15-19), with contact inversion above 9.
  Assumes sequence event inputs are one-cycle pulses and state inputs are levels,
  all synchronous to core_clk_i.
*/
// Contract
// - Selector 0-4 or 10-14 gives timed mode triggered by start command, starting, bypass, stop command or shutdown complete.
// - With a nonzero delay the trigger starts a seconds timer of up to 999 s and the output changes when it expires.
// - With zero delay the output changes at the trigger itself.
// - After the delay has ended the output returns to rest once the starter has been ready for one second.
// - A new start aborts any timed sequence in progress to idle unless that cycle moves it to ON or HOLD;
// only a start that is the trigger resets the timer and restarts the sequence.
// - Selector 5-9 or 15-19 gives state mode showing fault, operating, ready, starting or bypass.
// - State mode ignores the delay and follows the state directly.
// - The fault indication covers only fault codes 05, 06, 07, 08, 12 and 15.
// - Operating is shown whenever the starter is neither ready nor faulted.
// - The delay setting accepts 0 to 999 s and resets to 0.
// - Selector and delay changes are refused during soft start or soft stop.
`timescale 1ns/1ps
module pro_relay #(
  parameter int unsigned TICKS = pro_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  // Settings write port
  input  wire logic       set_wr_i,
  input  wire logic [4:0] relay_function_select_i,
  input  wire logic [9:0] relay_delay_seconds_i,
  output logic            set_refused_o,
  output logic [4:0]      relay_function_select_o,
  output logic [9:0]      relay_delay_seconds_o,
  // Starter sequence events
  input  wire logic       ev_start_cmd_i,
  input  wire logic       ev_starting_i,
  input  wire logic       ev_bypass_i,
  input  wire logic       ev_stop_cmd_i,
  input  wire logic       ev_shutdown_i,
  // Starter state levels
  input  wire logic       st_ready_i,
  input  wire logic       st_starting_i,
  input  wire logic       st_bypass_i,
  input  wire logic       st_soft_stop_i,
  input  wire logic       st_faulted_i,
  input  wire logic [4:0] fault_code_i,
  // Relay contact drive
  output logic            relay_o
);

  typedef enum logic [3:0] {
    PRO_IDLE  = 4'b0001,
    PRO_WAIT  = 4'b0010,
    PRO_ON    = 4'b0100,
    PRO_HOLD  = 4'b1000
  } pro_state_t;

  typedef struct packed {
    pro_state_t  fsm;
    logic [4:0]  sel;
    logic [9:0]  delay;
    logic [9:0]  secs;
    logic        refused;
    logic        relay;
  } pro_st_t;

  pro_st_t s_q;
  pro_st_t s_d;
  logic    tick;
  logic    tick_restart;

  function automatic logic [3:0] pro_base(input logic [4:0] sel);
    pro_base = (sel >= pro_pkg::SEL_INVERT_BASE) ? 4'(sel - pro_pkg::SEL_INVERT_BASE)
                                                 : sel[3:0];
  endfunction

  function automatic logic pro_elec_fault(input logic [4:0] c);
    pro_elec_fault = (c == pro_pkg::FLT_OUT_PHASE) || (c == pro_pkg::FLT_06) ||
                     (c == pro_pkg::FLT_07) || (c == pro_pkg::FLT_08) ||
                     (c == pro_pkg::FLT_12) || (c == pro_pkg::FLT_15);
  endfunction

  logic [3:0] base;
  logic       timed;
  logic       trig;
  logic       active;
  logic       state_hit;

  pro_tick #(
    .TICKS (TICKS)
  ) u_tick (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .restart_i  (tick_restart),
    .tick_o     (tick)
  );

  always_comb begin
    base      = pro_base(s_q.sel);
    timed     = base <= {1'b0, pro_pkg::TRIG_SHUTDOWN};
    unique case (base[2:0])
      pro_pkg::TRIG_START_CMD: trig = ev_start_cmd_i;
      pro_pkg::TRIG_STARTING:  trig = ev_starting_i;
      pro_pkg::TRIG_BYPASS:    trig = ev_bypass_i;
      pro_pkg::TRIG_STOP_CMD:  trig = ev_stop_cmd_i;
      pro_pkg::TRIG_SHUTDOWN:  trig = ev_shutdown_i;
      default:                 trig = 1'b0;
    endcase
    // State mode: fault subset, operating, ready, starting, bypass.
    state_hit = 1'b0;
    if (base == 4'({1'b0, pro_pkg::ST_FAULT})) begin
      state_hit = st_faulted_i && pro_elec_fault(fault_code_i);
    end else if (base == 4'({1'b0, pro_pkg::ST_OPERATING})) begin
      state_hit = !st_ready_i && !st_faulted_i;
    end else if (base == 4'({1'b0, pro_pkg::ST_READY})) begin
      state_hit = st_ready_i;
    end else if (base == pro_pkg::SEL_ST_STARTING) begin
      state_hit = st_starting_i;
    end else if (base == pro_pkg::SEL_ST_BYPASS) begin
      state_hit = st_bypass_i;
    end
  end

  assign active = (s_q.fsm == PRO_ON) || (s_q.fsm == PRO_HOLD);

  always_comb begin
    s_d          = s_q;
    s_d.refused  = 1'b0;
    tick_restart = 1'b0;
    // Settings are frozen while the starter is ramping up or down.
    if (set_wr_i) begin
      if (st_starting_i || st_soft_stop_i) begin
        s_d.refused = 1'b1;
      end else if (relay_function_select_i <= pro_pkg::SEL_MAX &&
                   relay_delay_seconds_i <= pro_pkg::DELAY_MAX) begin
        s_d.sel   = relay_function_select_i;
        s_d.delay = relay_delay_seconds_i;
        s_d.fsm   = PRO_IDLE;
      end else begin
        s_d.refused = 1'b1;
      end
    end
    if (timed && !set_wr_i) begin
      // A fresh start command returns the cycle to idle unless it is itself the trigger or the case below moves it to ON or HOLD.
      if (ev_start_cmd_i && s_q.fsm != PRO_IDLE && !trig) begin
        s_d.fsm = PRO_IDLE;
      end
      if (trig) begin
        s_d.secs     = 10'h000;
        tick_restart = 1'b1;
        if (s_q.delay == 10'h000) begin
          s_d.fsm = PRO_ON;
        end else begin
          s_d.fsm = PRO_WAIT;
        end
      end else begin
        unique case (s_q.fsm)
          PRO_IDLE: begin
          end
          PRO_WAIT: begin
            if (tick) begin
              s_d.secs = s_q.secs + 10'h001;
              if (s_q.secs + 10'h001 >= s_q.delay) begin
                s_d.fsm = PRO_ON;
              end
            end
          end
          PRO_ON: begin
            if (st_ready_i) begin
              s_d.fsm      = PRO_HOLD;
              s_d.secs     = 10'h000;
              tick_restart = 1'b1;
            end
          end
          PRO_HOLD: begin
            if (!st_ready_i) begin
              s_d.fsm = PRO_ON;
            end else if (tick && s_q.secs + 10'h001 >= 10'(pro_pkg::READY_HOLD_S)) begin
              s_d.fsm = PRO_IDLE;
            end
          end
        endcase
      end
    end
    // Contact drive: invert above 9 so the rest state is closed.
    if (timed) begin
      s_d.relay = active ^ (s_q.sel >= pro_pkg::SEL_INVERT_BASE);
    end else begin
      s_d.relay = state_hit ^ (s_q.sel >= pro_pkg::SEL_INVERT_BASE);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s_q.fsm     <= PRO_IDLE;
      s_q.sel     <= pro_pkg::SEL_RESET;
      s_q.delay   <= pro_pkg::DELAY_RESET;
      s_q.secs    <= 10'h000;
      s_q.refused <= 1'b0;
      s_q.relay   <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign relay_o                 = s_q.relay;
  assign set_refused_o           = s_q.refused;
  assign relay_function_select_o = s_q.sel;
  assign relay_delay_seconds_o   = s_q.delay;
endmodule // pro_relay

// *** bench/pro_relay_asserts.sv ***
/* Assertions for the relay output block.
   Bound to pro_relay; sees only its ports, one clock domain. */
`timescale 1ns/1ps
module pro_relay_asserts #(
  parameter int unsigned TICKS = 10
) (
  // Every port of the block, watched only
  input wire logic       core_clk_i, rst_i, set_wr_i, set_refused_o, relay_o,
  input wire logic [4:0] relay_function_select_i, relay_function_select_o, fault_code_i,
  input wire logic [9:0] relay_delay_seconds_i, relay_delay_seconds_o,
  input wire logic       ev_start_cmd_i, ev_starting_i, ev_bypass_i, ev_stop_cmd_i,
  input wire logic       ev_shutdown_i, st_ready_i, st_starting_i, st_bypass_i,
  input wire logic       st_soft_stop_i, st_faulted_i
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  wire logic busy = st_starting_i || st_soft_stop_i;
  wire logic [4:0] sel = relay_function_select_o;
  sequence trig0_s;
    sel == 5'h00 && relay_delay_seconds_o == 10'h000 && ev_start_cmd_i && !set_wr_i
      ##1 !set_wr_i [*2];
  endsequence
  reset_rest_a: assert property (disable iff (1'b0) rst_i |=> !relay_o && sel == 5'h06
    && relay_delay_seconds_o == 10'h000) else $error("reset values wrong");
  zero_delay_a: assert property (trig0_s |-> ##[0:1] relay_o)
    else $error("zero delay output late");
  delay_wait_a: assert property (sel == 5'h01 && relay_delay_seconds_o != 10'h000
    && ev_starting_i && !relay_o |=> !relay_o [*3]) else $error("delay skipped");
  ready_state_a: assert property ((sel == 5'h07 && $stable(st_ready_i)) [*4]
    |-> relay_o == st_ready_i) else $error("ready state wrong");
  bypass_inv_a: assert property ((sel == 5'h13 && $stable(st_bypass_i)) [*4]
    |-> relay_o == !st_bypass_i) else $error("inverted bypass wrong");
  fault_only_a: assert property ((sel == 5'h05 && $stable({st_faulted_i, fault_code_i})) [*4]
    |-> relay_o == (st_faulted_i && fault_code_i inside {5'h05, 5'h06, 5'h07, 5'h08,
    5'h0c, 5'h0f})) else $error("fault subset wrong");
  operating_a: assert property ((sel == 5'h06 && $stable({st_ready_i, st_faulted_i})) [*4]
    |-> relay_o == !(st_ready_i || st_faulted_i)) else $error("operating wrong");
  refuse_busy_a: assert property (set_wr_i && busy |=> set_refused_o && $stable(sel))
    else $error("busy write taken");
  refuse_range_a: assert property (set_wr_i && (relay_function_select_i > 5'h13
    || relay_delay_seconds_i > 10'h3e7) |=> set_refused_o && $stable(relay_delay_seconds_o))
    else $error("range write taken");
  accept_a: assert property (set_wr_i && !busy && relay_function_select_i <= 5'h13
    && relay_delay_seconds_i <= 10'h3e7 |=> !set_refused_o
    && relay_delay_seconds_o == $past(relay_delay_seconds_i)) else $error("write lost");
endmodule // pro_relay_asserts
bind pro_relay pro_relay_asserts #(.TICKS(TICKS)) u_asserts (.*);

// *** bench/pro_contact_model.sv ***
/* Relay contact pair driven by the block's coil output.
   Assumes 1 on the coil means energised and the contact closed. */
`timescale 1ns/1ps
module pro_contact_model (
  // Coil in, contact out
  input  wire logic coil_i,
  output logic      closed_o,
  output int        flips_o
);
  initial flips_o = 0;
  always @(coil_i) flips_o++;
  assign closed_o = coil_i;
endmodule // pro_contact_model

// *** bench/tb.sv ***
/* Self-checking bench for the relay output block with a reference model.
   Assumes TICKS is cut to 10 cycles, so one second is ten clocks. */
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("ERROR %0t got %h want %h", $time, a, b); end end
module tb;
  localparam int T = 10;
  logic       core_clk_i = 0, rst_i = 1, set_wr_i = 0, relay_o, set_refused_o, closed;
  // Ready during reset, so the reset selector's operating indication stays off.
  logic [4:0] sel_i = 0, sel_o, code = 0, ev = 0, st = 5'h01;
  int         flips, f0;
  logic [9:0] dly_i = 0, dly_o;
  int         bad_count = 0, total_checks = 0, seed = 11, cyc = 0, m_sel = 6, m_dly = 0;
  always #5 core_clk_i = ~core_clk_i;
  pro_relay #(.TICKS(T)) i_dut (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .set_wr_i(set_wr_i),
    .relay_function_select_i(sel_i), .relay_delay_seconds_i(dly_i),
    .set_refused_o(set_refused_o), .relay_function_select_o(sel_o),
    .relay_delay_seconds_o(dly_o), .ev_start_cmd_i(ev[0]), .ev_starting_i(ev[1]),
    .ev_bypass_i(ev[2]), .ev_stop_cmd_i(ev[3]), .ev_shutdown_i(ev[4]),
    .st_ready_i(st[0]), .st_starting_i(st[1]), .st_bypass_i(st[2]),
    .st_soft_stop_i(st[3]), .st_faulted_i(st[4]), .fault_code_i(code), .relay_o(relay_o));
  pro_contact_model i_contact (.coil_i(relay_o), .closed_o(closed), .flips_o(flips));
  function automatic bit m_state(int s);
    bit flt = st[4] && (code inside {5, 6, 7, 8, 12, 15});
    case (s % 10)
      5: return flt;
      6: return !(st[0] || st[4]);
      7: return st[0];
      8: return st[1];
      default: return st[2];
    endcase
  endfunction
  task automatic wait_n(int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  task automatic wr(int s, int d);
    bit rf = st[1] || st[3] || s > 19 || d > 999;
    set_wr_i = 1;
    sel_i = s[4:0];
    dly_i = d[9:0];
    wait_n(1);
    set_wr_i = 0;
    if (!rf) begin
      m_sel = s;
      m_dly = d;
    end
    `CHK(set_refused_o, rf)
    `CHK(sel_o, 5'(m_sel))
    `CHK(dly_o, 10'(m_dly))
    wait_n(1);
  endtask
  task automatic pulse(int i);
    ev[i] = 1;
    wait_n(1);
    ev[i] = 0;
  endtask
  task automatic end_of_test();
    if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      end_of_test();
    end
  end
  initial begin
    wait_n(8);
    rst_i = 0;
    wait_n(1);
    `CHK(closed, 1'b0)
    `CHK(dly_o, 10'h000)
    st = 5'h02;
    wr(1, 3);
    st = 5'h08;
    wr(1, 3);
    st = 0;
    wr(20, 0);
    wr(0, 1000);
    wr(19, 999);
    for (int s = 5; s < 20; s++) begin
      if (s % 10 < 5) continue;
      st = 0;
      wr(s, ($random(seed) & 1023) % 1000);
      repeat (6) begin
        st = 5'($random(seed));
        code = ($random(seed) & 1) ? 5'h0c : 5'($random(seed));
        wait_n(5);
        `CHK(closed, m_state(s) ^ (s > 9))
      end
    end
    for (int s = 0; s < 15; s++) begin
      if (s % 10 > 4) continue;
      st = 0;
      wr(s, 0);
      pulse((s + 1) % 5);
      wait_n(2);
      `CHK(closed, s > 9)
      pulse(s % 10);
      wait_n(2);
      `CHK(closed, s < 10)
      st[0] = 1;
      wait_n(T + 4);
      `CHK(closed, s > 9)
    end
    st = 0;
    wr(1, 2);
    pulse(1);
    wait_n(T);
    `CHK(closed, 1'b0)
    ev = 5'h01;
    wait_n(1);
    ev = 5'h02;
    wait_n(1);
    ev = 5'h00;
    f0 = flips;
    wait_n(2 * T - 4);
    `CHK(closed, 1'b0)
    `CHK(flips, f0)
    wait_n(10);
    `CHK(closed, 1'b1)
    end_of_test();
  end
endmodule // tb
